// [rtl/ctm_monitor.sv]
/*
  Charge termination monitor: full-charge detection by temperature
  slope, voltage drop and overcharge count, temperature windows, empty
  detection and charger request words, behind an AXI4-Lite slave.
  Assumes measurements arrive synchronous to i_core_clk with a one-cycle
  strobe, and that a separate SMBus master sends the request words.
*/
// Operation
// - Eight rising temperature boundary codes held.
// - Eight rising C-rate boundary codes held.
// - Residual capacity byte per temperature column.
// - Empty voltage is 8000 plus four code.
// - Charger current and voltage requests for broadcast.
// - Three full methods run together, any wins.
// - Temperature rise per sample ends charge.
// - Slope end loads state of charge value.
// - All methods held off after charge start.
// - Drop method needs rate and stable current.
// - Voltage drop from peak ends charge.
// - Overcharge method at or below max rate integrates charge.
// - Overcharge ends when charge reaches limit.
// - High temperature sets alarm, stop if charging.
// - Below minimum temperature charging is disabled.
// - Above maximum charging temperature charging stops.
// - Above maximum discharge temperature discharging stops.
// - After overheat charging waits below fifty degrees.
// - Empty valid after consecutive low checks.
`timescale 1ns/100ps
`default_nettype none
module ctm_monitor #(
  parameter int unsigned TICK_CYCLES = ctm_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_rst,
  // Measurements
  input  wire logic         i_meas_valid,
  input  wire logic [15:0]  i_temp_dc,
  input  wire logic [15:0]  i_pack_mv,
  input  wire logic [15:0]  i_curr_ma,
  input  wire logic [7:0]   i_rate_code,
  input  wire logic         i_charging,
  input  wire logic         i_discharging,
  // AXI4-Lite write
  input  wire logic [7:0]   i_awaddr,
  input  wire logic         i_awvalid,
  output logic              o_awready,
  input  wire logic [31:0]  i_wdata,
  input  wire logic [3:0]   i_wstrb,
  input  wire logic         i_wvalid,
  output logic              o_wready,
  output logic [1:0]        o_bresp,
  output logic              o_bvalid,
  input  wire logic         i_bready,
  // AXI4-Lite read
  input  wire logic [7:0]   i_araddr,
  input  wire logic         i_arvalid,
  output logic              o_arready,
  output logic [31:0]       o_rdata,
  output logic [1:0]        o_rresp,
  output logic              o_rvalid,
  input  wire logic         i_rready,
  // Status
  output logic              o_full,
  output logic              o_stop_charge_flag,
  output logic              o_over_temp,
  output logic              o_charge_en,
  output logic              o_discharge_en,
  output logic              o_empty,
  output logic [15:0]       o_empty_mv,
  output logic [15:0]       o_req_curr_ma,
  output logic [15:0]       o_req_volt_mv
);
  typedef struct packed {
    logic [7:0][7:0] temp_boundary_codes;
    logic [7:0][7:0] rate_boundary_codes;
    logic [7:0][7:0] residual_capacity_pct;
    logic [15:0] sample_interval;
    logic [15:0] full_detect_holdoff;
    logic [15:0] slope_method_soc_value;
    logic [15:0] temp_rise_threshold;
    logic [15:0] voltage_drop_threshold;
    logic [7:0]  drop_method_min_rate;
    logic [7:0]  current_stability_factor;
    logic [7:0]  overcharge_max_rate;
    logic [31:0] overcharge_soc_limit;
    logic [15:0] high_temp_alarm_limit;
    logic [15:0] charge_min_temp;
    logic [15:0] charge_max_temp;
    logic [15:0] discharge_max_temp;
    logic [7:0]  eod_code;
    logic [7:0]  empty_confirm_count;
    logic [15:0] req_curr;
    logic [15:0] req_volt;
    logic [31:0] tick_cnt;
    logic [15:0] samp_cnt;
    logic [15:0] hold_cnt;
    logic        prev_chg;
    logic        have_ref;
    logic [15:0] last_temp;
    logic [15:0] peak_mv;
    logic [15:0] last_curr;
    logic [31:0] soc;
    logic [7:0]  low_cnt;
    logic        full;
    logic [2:0]  cause;
    logic        over_temp;
    logic        stop_chg;
    logic        hot_latch;
    logic        chg_en;
    logic        dsg_en;
    logic        empty;
    logic [15:0] empty_mv;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ctm_state_t;

  ctm_state_t s_q;
  ctm_state_t s_d;

  function automatic logic [31:0] ctm_read(input ctm_state_t s,
                                           input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      ctm_pkg::ADDR_CTRL:    r = {s.req_volt, s.req_curr};
      ctm_pkg::ADDR_SAMPLE:  r = {16'h0000, s.sample_interval};
      ctm_pkg::ADDR_HOLDOFF: r = {16'h0000, s.full_detect_holdoff};
      ctm_pkg::ADDR_SLOPE:   r = {s.temp_rise_threshold,
                                  s.slope_method_soc_value};
      ctm_pkg::ADDR_DROP:    r = {s.current_stability_factor,
                                  s.drop_method_min_rate,
                                  s.voltage_drop_threshold};
      ctm_pkg::ADDR_OVCH:    r = s.overcharge_soc_limit;
      ctm_pkg::ADDR_TEMPLIM: r = {s.charge_min_temp,
                                  s.high_temp_alarm_limit};
      ctm_pkg::ADDR_MAXT:    r = {s.discharge_max_temp, s.charge_max_temp};
      ctm_pkg::ADDR_EOD:     r = {8'h00, s.overcharge_max_rate,
                                  s.empty_confirm_count, s.eod_code};
      ctm_pkg::ADDR_CHGREQ:  r = {16'h0000, s.empty_mv};
      ctm_pkg::ADDR_STATUS:  r = {22'h000000, s.hot_latch, s.empty,
                                  s.dsg_en, s.chg_en, s.stop_chg,
                                  s.over_temp, s.cause, s.full};
      ctm_pkg::ADDR_SOC:     r = s.soc;
      ctm_pkg::ADDR_TBND:    r = s.temp_boundary_codes[3:0];
      ctm_pkg::ADDR_TBND + 8'h04: r = s.temp_boundary_codes[7:4];
      ctm_pkg::ADDR_RBND:    r = s.rate_boundary_codes[3:0];
      ctm_pkg::ADDR_RBND + 8'h04: r = s.rate_boundary_codes[7:4];
      ctm_pkg::ADDR_RESID:   r = s.residual_capacity_pct[3:0];
      ctm_pkg::ADDR_RESID + 8'h04: r = s.residual_capacity_pct[7:4];
      default:               r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  function automatic logic ctm_mapped(input logic [7:0] a);
    return (a <= ctm_pkg::ADDR_SOC) || (a == ctm_pkg::ADDR_TBND) ||
           (a == ctm_pkg::ADDR_TBND + 8'h04) ||
           (a == ctm_pkg::ADDR_RBND) || (a == ctm_pkg::ADDR_RBND + 8'h04) ||
           (a == ctm_pkg::ADDR_RESID) || (a == ctm_pkg::ADDR_RESID + 8'h04);
  endfunction

  logic        tick;
  logic        samp;
  logic        armed;
  logic        new_chg;
  logic        wr_fire;
  logic        slope_hit;
  logic        drop_hit;
  logic        ovch_hit;
  logic        drop_en;
  logic        ovch_en;
  logic        stable;
  logic [15:0] cdiff;
  logic [15:0] eod_level;

  always_comb begin
    s_d       = s_q;
    tick      = (s_q.tick_cnt >= TICK_CYCLES - 1);
    samp      = 1'b0;
    new_chg   = i_charging && !s_q.prev_chg;
    armed     = (s_q.hold_cnt >= s_q.full_detect_holdoff);
    // Current is stable when it moved by no more than the set factor.
    cdiff     = (i_curr_ma > s_q.last_curr) ? i_curr_ma - s_q.last_curr
                                            : s_q.last_curr - i_curr_ma;
    stable    = (cdiff[15:8] == 8'h00) &&
                (cdiff[7:0] <= s_q.current_stability_factor);
    drop_en   = (i_rate_code >= s_q.drop_method_min_rate) && stable;
    ovch_en   = (i_rate_code <= s_q.overcharge_max_rate);
    eod_level = ctm_pkg::EOD_MV_BASE +
                {6'h00, s_q.eod_code, 2'b00};
    slope_hit = 1'b0;
    drop_hit  = 1'b0;
    ovch_hit  = 1'b0;
    wr_fire   = 1'b0;

    s_d.prev_chg = i_charging;
    s_d.empty_mv = eod_level;
    s_d.tick_cnt = tick ? 32'h0000_0000 : s_q.tick_cnt + 32'h0000_0001;
    if (tick && i_charging && !armed) begin
      s_d.hold_cnt = s_q.hold_cnt + 16'h0001;
    end
    if (tick) begin
      s_d.samp_cnt = s_q.samp_cnt + 16'h0001;
      if (s_q.samp_cnt + 16'h0001 >= s_q.sample_interval) begin
        s_d.samp_cnt = 16'h0000;
        samp = 1'b1;
      end
    end

    if (i_meas_valid && i_charging) begin
      s_d.last_curr = i_curr_ma;
      if (ovch_en) begin
        s_d.soc = s_q.soc + {16'h0000, i_curr_ma};
      end
      if (samp) begin
        s_d.have_ref  = 1'b1;
        s_d.last_temp = i_temp_dc;
        if (i_pack_mv > s_q.peak_mv) begin
          s_d.peak_mv = i_pack_mv;
        end
        // Methods evaluate together; any one ends the charge.
        slope_hit = s_q.have_ref && (i_temp_dc > s_q.last_temp) &&
                    (i_temp_dc - s_q.last_temp >=
                     s_q.temp_rise_threshold);
        drop_hit  = s_q.have_ref && drop_en && (s_q.peak_mv > i_pack_mv) &&
                    (s_q.peak_mv - i_pack_mv >=
                     s_q.voltage_drop_threshold);
      end
      ovch_hit = ovch_en && (s_d.soc >= s_q.overcharge_soc_limit);
    end
    if (armed && !s_q.full && (slope_hit || drop_hit || ovch_hit)) begin
      s_d.full  = 1'b1;
      s_d.cause = {ovch_hit, drop_hit, slope_hit};
      if (slope_hit) begin
        s_d.soc = {16'h0000, s_q.slope_method_soc_value};
      end
    end
    if (new_chg) begin
      s_d.full     = 1'b0;
      s_d.cause    = 3'b000;
      s_d.hold_cnt = 16'h0000;
      s_d.have_ref = 1'b0;
      s_d.peak_mv  = 16'h0000;
      s_d.soc      = 32'h0000_0000;
    end

    if (i_meas_valid) begin
      s_d.over_temp = (i_temp_dc > s_q.high_temp_alarm_limit);
      s_d.stop_chg  = s_d.over_temp && i_charging;
      if (i_charging && i_temp_dc > s_q.charge_max_temp) begin
        s_d.hot_latch = 1'b1;
      end else if (i_temp_dc < ctm_pkg::HYST_TEMP_DC) begin
        s_d.hot_latch = 1'b0;
      end
      s_d.chg_en = !(i_temp_dc < s_q.charge_min_temp) &&
                   !s_d.hot_latch && !s_q.full;
      s_d.dsg_en = !(i_discharging &&
                     i_temp_dc > s_q.discharge_max_temp);
      if (tick) begin
        if (i_pack_mv < eod_level) begin
          if (s_q.low_cnt < s_q.empty_confirm_count) begin
            s_d.low_cnt = s_q.low_cnt + 8'h01;
          end
        end else begin
          s_d.low_cnt = 8'h00;
        end
      end
      s_d.empty = (s_d.low_cnt >= s_q.empty_confirm_count) &&
                  (i_pack_mv < eod_level);
    end

    // AXI4-Lite write: address and data in any order, then response.
    if (i_awvalid && !s_q.aw_got) begin
      s_d.aw_got  = 1'b1;
      s_d.aw_addr = i_awaddr;
    end
    if (i_wvalid && !s_q.w_got) begin
      s_d.w_got  = 1'b1;
      s_d.w_data = i_wdata;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      wr_fire   = 1'b1;
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = ctm_mapped(s_q.aw_addr) && s_q.aw_addr !=
                   ctm_pkg::ADDR_STATUS ? ctm_pkg::RESP_OKAY
                                        : ctm_pkg::RESP_SLVERR;
    end
    if (s_q.bvalid && i_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (wr_fire) begin
      case (s_q.aw_addr)
        ctm_pkg::ADDR_CTRL: begin
          s_d.req_curr = s_q.w_data[15:0];
          s_d.req_volt = s_q.w_data[31:16];
        end
        ctm_pkg::ADDR_SAMPLE:  s_d.sample_interval = s_q.w_data[15:0];
        ctm_pkg::ADDR_HOLDOFF: s_d.full_detect_holdoff = s_q.w_data[15:0];
        ctm_pkg::ADDR_SLOPE: begin
          s_d.slope_method_soc_value = s_q.w_data[15:0];
          s_d.temp_rise_threshold    = s_q.w_data[31:16];
        end
        ctm_pkg::ADDR_DROP: begin
          s_d.voltage_drop_threshold   = s_q.w_data[15:0];
          s_d.drop_method_min_rate     = s_q.w_data[23:16];
          s_d.current_stability_factor = s_q.w_data[31:24];
        end
        ctm_pkg::ADDR_OVCH: s_d.overcharge_soc_limit = s_q.w_data;
        ctm_pkg::ADDR_TEMPLIM: begin
          s_d.high_temp_alarm_limit = s_q.w_data[15:0];
          s_d.charge_min_temp       = s_q.w_data[31:16];
        end
        ctm_pkg::ADDR_MAXT: begin
          s_d.charge_max_temp    = s_q.w_data[15:0];
          s_d.discharge_max_temp = s_q.w_data[31:16];
        end
        ctm_pkg::ADDR_EOD: begin
          s_d.eod_code            = s_q.w_data[7:0];
          s_d.empty_confirm_count = s_q.w_data[15:8];
          s_d.overcharge_max_rate = s_q.w_data[23:16];
        end
        // Boundary tables take whole words; byte strobes are ignored.
        ctm_pkg::ADDR_TBND: s_d.temp_boundary_codes[3:0] = s_q.w_data;
        ctm_pkg::ADDR_TBND + 8'h04:
          s_d.temp_boundary_codes[7:4] = s_q.w_data;
        ctm_pkg::ADDR_RBND: s_d.rate_boundary_codes[3:0] = s_q.w_data;
        ctm_pkg::ADDR_RBND + 8'h04:
          s_d.rate_boundary_codes[7:4] = s_q.w_data;
        ctm_pkg::ADDR_RESID:
          s_d.residual_capacity_pct[3:0] = s_q.w_data;
        ctm_pkg::ADDR_RESID + 8'h04:
          s_d.residual_capacity_pct[7:4] = s_q.w_data;
        default: s_d.req_curr = s_d.req_curr;
      endcase
    end

    if (i_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = ctm_read(s_q, i_araddr);
      s_d.rresp  = ctm_mapped(i_araddr) ? ctm_pkg::RESP_OKAY
                                        : ctm_pkg::RESP_SLVERR;
    end else if (s_q.rvalid && i_rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_awready          = !s_q.aw_got;
  assign o_wready           = !s_q.w_got;
  assign o_bvalid           = s_q.bvalid;
  assign o_bresp            = s_q.bresp;
  assign o_arready          = !s_q.rvalid;
  assign o_rvalid           = s_q.rvalid;
  assign o_rdata            = s_q.rdata;
  assign o_rresp            = s_q.rresp;
  assign o_full             = s_q.full;
  assign o_stop_charge_flag = s_q.stop_chg;
  assign o_over_temp        = s_q.over_temp;
  assign o_charge_en        = s_q.chg_en;
  assign o_discharge_en     = s_q.dsg_en;
  assign o_empty            = s_q.empty;
  assign o_empty_mv         = s_q.empty_mv;
  assign o_req_curr_ma      = s_q.req_curr;
  assign o_req_volt_mv      = s_q.req_volt;

  property p_over_temp;
    @(posedge i_core_clk) disable iff (i_rst)
      i_meas_valid && (i_temp_dc > s_q.high_temp_alarm_limit)
      |=> o_over_temp;
  endproperty
  a_over_temp: assert property (p_over_temp)
    else $error("over temperature flag missed");

  property p_stop_chg;
    @(posedge i_core_clk) disable iff (i_rst)
      o_stop_charge_flag |-> o_over_temp;
  endproperty
  a_stop_chg: assert property (p_stop_chg)
    else $error("stop charge without over temperature");

  property p_min_temp;
    @(posedge i_core_clk) disable iff (i_rst)
      i_meas_valid && (i_temp_dc < s_q.charge_min_temp) |=> !o_charge_en;
  endproperty
  a_min_temp: assert property (p_min_temp)
    else $error("charging enabled below minimum temperature");

  property p_hyst;
    @(posedge i_core_clk) disable iff (i_rst)
      s_q.hot_latch && i_meas_valid &&
      (i_temp_dc >= ctm_pkg::HYST_TEMP_DC) |=> !o_charge_en;
  endproperty
  a_hyst: assert property (p_hyst)
    else $error("charging resumed above hysteresis point");

  property p_dsg;
    @(posedge i_core_clk) disable iff (i_rst)
      i_meas_valid && i_discharging &&
      (i_temp_dc > s_q.discharge_max_temp) |=> !o_discharge_en;
  endproperty
  a_dsg: assert property (p_dsg)
    else $error("discharge enabled above maximum temperature");

  property p_holdoff;
    @(posedge i_core_clk) disable iff (i_rst)
      !armed && !s_q.full |=> !o_full;
  endproperty
  a_holdoff: assert property (p_holdoff)
    else $error("full detected during holdoff");

  property p_new_chg;
    @(posedge i_core_clk) disable iff (i_rst)
      new_chg |=> !o_full;
  endproperty
  a_new_chg: assert property (p_new_chg)
    else $error("full flag survived new charge");

  property p_slope_soc;
    @(posedge i_core_clk) disable iff (i_rst)
      $rose(o_full) && s_q.cause[0] |->
      s_q.soc == {16'h0000, $past(s_q.slope_method_soc_value)};
  endproperty
  a_slope_soc: assert property (p_slope_soc)
    else $error("slope end did not load charge value");

  // The level register still holds its reset value one cycle after reset.
  property p_eod_mv;
    @(posedge i_core_clk) disable iff (i_rst)
      !$past(i_rst) |->
      o_empty_mv == ctm_pkg::EOD_MV_BASE +
      {6'h00, $past(s_q.eod_code), 2'b00};
  endproperty
  a_eod_mv: assert property (p_eod_mv)
    else $error("empty voltage level wrong");
endmodule
`default_nettype wire

// [rtl/ctm_pkg.sv]
/*
  Constants shared by the charge termination monitor: register map,
  field positions, reset values and timing counts.
  Assumes an AXI4-Lite master with 32-bit data on the other side.
*/
package ctm_pkg;
  localparam int unsigned CLK_HZ        = 40000000;
  localparam int unsigned TICK_US       = 1000;
  localparam int unsigned TICK_CYC      = (CLK_HZ / 1000000) * TICK_US;
  localparam logic [15:0] EOD_MV_BASE   = 16'h1f40;
  localparam int unsigned EOD_MV_SHIFT  = 2;
  localparam logic [15:0] HYST_TEMP_DC  = 16'h01f4;
  localparam logic [7:0]  TEMP_CODE_OFS = 8'hc8;
  localparam logic [7:0]  RATE_FACTOR   = 8'h07;
  localparam logic [7:0]  FULL_PCT      = 8'hff;
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_SAMPLE   = 8'h04;
  localparam logic [7:0]  ADDR_HOLDOFF  = 8'h08;
  localparam logic [7:0]  ADDR_SLOPE    = 8'h0c;
  localparam logic [7:0]  ADDR_DROP     = 8'h10;
  localparam logic [7:0]  ADDR_OVCH     = 8'h14;
  localparam logic [7:0]  ADDR_TEMPLIM  = 8'h18;
  localparam logic [7:0]  ADDR_MAXT     = 8'h1c;
  localparam logic [7:0]  ADDR_EOD      = 8'h20;
  localparam logic [7:0]  ADDR_CHGREQ   = 8'h24;
  localparam logic [7:0]  ADDR_STATUS   = 8'h28;
  localparam logic [7:0]  ADDR_SOC      = 8'h2c;
  localparam logic [7:0]  ADDR_TBND     = 8'h40;
  localparam logic [7:0]  ADDR_RBND     = 8'h60;
  localparam logic [7:0]  ADDR_RESID    = 8'h80;
  localparam int unsigned ST_FULL       = 0;
  localparam int unsigned ST_BY_SLOPE   = 1;
  localparam int unsigned ST_BY_DROP    = 2;
  localparam int unsigned ST_BY_OVCH    = 3;
  localparam int unsigned ST_OVER_TEMP  = 4;
  localparam int unsigned ST_STOP_CHG   = 5;
  localparam int unsigned ST_CHG_EN     = 6;
  localparam int unsigned ST_DSG_EN     = 7;
  localparam int unsigned ST_EMPTY      = 8;
  localparam int unsigned ST_HOT_LATCH  = 9;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;
  typedef enum logic [1:0] {
    CTM_IDLE  = 2'b00,
    CTM_CHG   = 2'b01,
    CTM_DSG   = 2'b10
  } ctm_mode_t;
endpackage

// [tb/ctm_charger_model.sv]
/*
  Behavioural charger that delivers the current the pack requests.
  Assumes the request word and charge enable are registered outputs.
*/
`timescale 1ns/100ps
`default_nettype none
module ctm_charger_model (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // Requests from the pack
  input  wire logic [15:0] i_req_curr_ma,
  input  wire logic        i_charge_en,
  // Current delivered into the pack
  output logic [15:0]      o_curr_ma
);
  // Like a real charger it cuts current, on the clock edge after permission goes away.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_curr_ma <= 16'h0000;
    end else begin
      o_curr_ma <= i_charge_en ? i_req_curr_ma : 16'h0000;
    end
  end
endmodule
`default_nettype wire

// [tb/charge_termination_monitor_tb.sv]
/*
  Self-checking bench for the charge termination monitor.
  Assumes the charger model closes the current loop into the pack.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module charge_termination_monitor_tb;
  logic        core_clk, rst, meas_valid, charging, discharging;
  logic [15:0] temp_dc, pack_mv, curr_ma, empty_mv, req_curr, req_volt;
  logic [7:0]  rate_code, awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rdata, rd_val;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  logic        full, stop, over_temp, chg_en, dsg_en, empty;
  int          fail_count, total_checks;
  logic [7:0]  cfg_a [0:14] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
    8'h1c, 8'h20, 8'h00, 8'h40, 8'h44, 8'h60, 8'h64, 8'h80, 8'h84};
  logic [31:0] cfg_d [0:14] = '{32'h1, 32'h3, 32'hffff_1234, 32'h0a20_ffff,
    32'hffff_ffff, 32'h0032_02bc, 32'h0258_0258, 32'h0000_024b,
    32'h3138_07d0, 32'h3223_1405, 32'h9696_7150, 32'h4030_2013,
    32'h6d6d_5a4d, 32'h080c_1932, 32'h0101_0101};

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  ctm_monitor #(.TICK_CYCLES(10)) dut_u (
    .i_core_clk(core_clk), .i_rst(rst), .i_meas_valid(meas_valid),
    .i_temp_dc(temp_dc), .i_pack_mv(pack_mv), .i_curr_ma(curr_ma),
    .i_rate_code(rate_code), .i_charging(charging),
    .i_discharging(discharging), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .o_full(full),
    .o_stop_charge_flag(stop), .o_over_temp(over_temp),
    .o_charge_en(chg_en), .o_discharge_en(dsg_en), .o_empty(empty),
    .o_empty_mv(empty_mv), .o_req_curr_ma(req_curr),
    .o_req_volt_mv(req_volt));

  ctm_charger_model chg_u (.i_core_clk(core_clk), .i_rst(rst),
    .i_req_curr_ma(req_curr), .i_charge_en(chg_en), .o_curr_ma(curr_ma));

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Ready is registered, so its value at the falling edge holds at the next
  // rising edge; deciding there avoids racing the design's own update.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_hs, w_hs, b_hs;
    b_hs = 1'b0;
    @(posedge core_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int n = 0; n < 100 && !b_hs; n++) begin
      @(negedge core_clk);
      aw_hs = awvalid && awready;
      w_hs  = wvalid && wready;
      b_hs  = bvalid;
      resp  = bresp;
      @(posedge core_clk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!b_hs) begin
      fail_count++;
      tally_and_finish();
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic ar_hs, r_hs;
    r_hs = 1'b0;
    @(posedge core_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int n = 0; n < 100 && !r_hs; n++) begin
      @(negedge core_clk);
      ar_hs  = arvalid && arready;
      r_hs   = rvalid;
      rd_val = rdata;
      resp   = rresp;
      @(posedge core_clk);
      if (ar_hs) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!r_hs) begin
      fail_count++;
      tally_and_finish();
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, e);
    rd(a);
    `CHK(rd_val & m, e)
  endtask

  task automatic meas(input logic [15:0] t, mv, input int n);
    @(posedge core_clk);
    temp_dc    <= t;
    pack_mv    <= mv;
    meas_valid <= 1'b1;
    repeat (n) @(posedge core_clk);
    meas_valid <= 1'b0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic new_charge();
    @(posedge core_clk);
    charging <= 1'b0;
    repeat (2) @(posedge core_clk);
    charging <= 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  initial begin
    {rst, meas_valid, charging, discharging} = 4'b1000;
    {awvalid, wvalid, bready, arvalid, rready} = 5'b00000;
    {awaddr, araddr, wdata} = 48'h0;
    {temp_dc, pack_mv, rate_code} = {16'h012c, 16'h2328, 8'h40};
    fail_count   = 0;
    total_checks = 0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rd_chk(ctm_pkg::ADDR_SOC, 32'hffff_ffff, 32'h0);
    for (int i = 0; i < 15; i++) wr(cfg_a[i], cfg_d[i]);
    for (int i = 9; i < 15; i++) rd_chk(cfg_a[i], '1, cfg_d[i]);
    rd(8'hfc);
    `CHK(rd_val, 32'h0)
    `CHK(resp, ctm_pkg::RESP_SLVERR)
    wr(ctm_pkg::ADDR_STATUS, 32'h0);
    `CHK(resp, ctm_pkg::RESP_SLVERR)
    rd_chk(ctm_pkg::ADDR_CHGREQ, '1, 32'd8000 + 32'd4 * 32'h4b);
    @(negedge core_clk);
    `CHK(empty_mv, 16'd8000 + 16'd4 * 16'h4b)
    `CHK({req_volt, req_curr}, 32'h3138_07d0)
    new_charge();
    meas(16'h0028, 16'h2328, 3);
    `CHK(chg_en, 1'b0)
    meas(16'h012c, 16'h2328, 3);
    `CHK(chg_en, 1'b1)
    meas(16'h0262, 16'h2328, 3);
    `CHK(chg_en, 1'b0)
    meas(16'h0226, 16'h2328, 3);
    `CHK(chg_en, 1'b0)
    meas(16'h01ea, 16'h2328, 3);
    `CHK(chg_en, 1'b1)
    @(posedge core_clk);
    charging    <= 1'b0;
    discharging <= 1'b1;
    meas(16'h0262, 16'h2328, 3);
    `CHK(dsg_en, 1'b0)
    meas(16'h012c, 16'h1f40, 1);
    `CHK({dsg_en, empty}, 2'b10)
    meas(16'h012c, 16'h1f40, 60);
    `CHK(empty, 1'b1)
    meas(16'h012c, 16'h2328, 3);
    @(posedge core_clk);
    discharging <= 1'b0;
    wr(ctm_pkg::ADDR_CHGREQ - 8'h24, 32'h3138_0064);
    wr(ctm_pkg::ADDR_OVCH, 32'h3e8);
    wr(ctm_pkg::ADDR_EOD, 32'h0020_024b);
    wr(ctm_pkg::ADDR_HOLDOFF, 32'ha);
    rate_code <= 8'h10;
    new_charge();
    meas(16'h012c, 16'h2328, 30);
    `CHK({full, curr_ma}, {1'b0, 16'h0064})
    meas(16'h012c, 16'h2328, 120);
    `CHK(full, 1'b1)
    rd_chk(ctm_pkg::ADDR_STATUS, 32'hf, 32'h9);
    wr(ctm_pkg::ADDR_EOD, 32'h0000_024b);
    wr(ctm_pkg::ADDR_SLOPE, 32'h000a_1234);
    wr(ctm_pkg::ADDR_HOLDOFF, 32'h3);
    rate_code <= 8'h40;
    new_charge();
    `CHK(full, 1'b0)
    meas(16'h012c, 16'h2328, 40);
    `CHK(full, 1'b0)
    meas(16'h013b, 16'h2328, 40);
    `CHK(full, 1'b1)
    rd_chk(ctm_pkg::ADDR_STATUS, 32'hf, 32'h3);
    rd_chk(ctm_pkg::ADDR_SOC, 32'hffff_ffff, 32'h1234);
    wr(ctm_pkg::ADDR_SLOPE, 32'hffff_0000);
    wr(ctm_pkg::ADDR_DROP, 32'h0a20_0032);
    wr(ctm_pkg::ADDR_CHGREQ - 8'h24, 32'h3138_07d0);
    new_charge();
    meas(16'h012c, 16'h2328, 40);
    `CHK({full, curr_ma}, {1'b0, 16'h07d0})
    meas(16'h012c, 16'h22ec, 40);
    `CHK(full, 1'b1)
    rd_chk(ctm_pkg::ADDR_STATUS, 32'hf, 32'h5);
    new_charge();
    meas(16'h02c6, 16'h2328, 3);
    `CHK({over_temp, stop}, 2'b11)
    tally_and_finish();
  end
endmodule
`undef CHK
`default_nettype wire
